// ==== hdl/imusrf_pkg.sv ====
package imusrf_pkg;
  localparam int CH_N = 7;
  localparam int CH_W = 20;
  localparam real CLK_HZ = 100.0e6;
  localparam real BASE_SPS = 819.2;
  localparam int TICK_CYCLES = $rtoi(CLK_HZ / BASE_SPS);
  localparam logic [6:0] OFF_GYRO0 = 7'h04;
  localparam logic [6:0] OFF_ACCL0 = 7'h0A;
  localparam logic [6:0] OFF_MAG0 = 7'h10;
  localparam logic [6:0] OFF_BARO = 7'h16;
  localparam logic [6:0] OFF_TEMP = 7'h18;
  localparam logic [6:0] OFF_GYRO_X_BIAS = 7'h1A;
  localparam logic [6:0] OFF_GYRO_Y_BIAS = 7'h1C;
  localparam logic [6:0] OFF_GYRO_Z_BIAS = 7'h1E;
  localparam logic [6:0] OFF_SAMPLE_PERIOD = 7'h36;
  localparam logic [6:0] OFF_FILTER_RANGE = 7'h38;
  localparam logic [6:0] OFF_SLOW_SENSOR_SEQUENCE_COUNTER = 7'h3A;
  localparam logic [6:0] OFF_DIAG = 7'h3C;
  localparam logic [15:0] SPC_RESET = 16'h0001;
  localparam logic [15:0] FRC_RESET = 16'h0402;
  localparam logic [15:0] BIAS_RESET = 16'h0000;
  localparam logic [15:0] SPC_MASK = 16'h1F01;
  localparam logic [15:0] FRC_MASK = 16'h0707;
  localparam int SPC_CLK_BIT = 0;
  localparam int SPC_DEC_LSB = 8;
  localparam int FRC_B_LSB = 0;
  localparam int FRC_RNG_LSB = 8;
  localparam int DIAG_NEW_BIT = 7;
  localparam logic [2:0] RNG_1000 = 3'h4;
  localparam logic [2:0] RNG_500 = 3'h2;
  localparam logic [2:0] RNG_250 = 3'h1;
  localparam logic [2:0] MIN_B_500 = 3'h2;
  localparam logic [2:0] MIN_B_250 = 3'h4;
  localparam logic [4:0] DEC_MAX = 5'h10;
  localparam logic [4:0] SLOW_D_LIMIT = 5'h04;
  localparam logic [6:0] SEQ_FULL = 7'h10;
  typedef logic [CH_N-1:0][CH_W-1:0] imusrf_chan_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [15:0] wdata;
  } imusrf_reg_req_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STAGE1 = 2'b01,
    ST_STAGE2 = 2'b10
  } imusrf_state_t;
endpackage : imusrf_pkg

// ==== hdl/imusrf_filter.sv ====
`timescale 1ns/1ps
module imusrf_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem_r[rp_r];
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r <= wp_r + 1'b1;
      end
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_nxt;
      in_ready <= cnt_nxt != (AW+1)'(DEPTH);
      out_valid <= cnt_nxt != '0;
    end
  end
endmodule : imusrf_fifo

module imusrf_filter #(
  parameter int TICK_CYCLES = imusrf_pkg::TICK_CYCLES,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register access from the serial port
  input wire imusrf_pkg::imusrf_reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  // raw inertial samples from the front end
  input wire logic raw_valid,
  output logic raw_ready,
  input wire imusrf_pkg::imusrf_chan_t raw_data,
  // slow sensors
  input wire logic [2:0][15:0] mag_in,
  input wire logic [15:0] baro_in,
  // aux line 4 pin and its general-purpose settings
  input wire logic aux4_in,
  output logic aux4_out,
  output logic aux4_oe,
  input wire logic gpio4_dir,
  input wire logic gpio4_level,
  // update markers
  output logic sample_update,
  output logic slow_update
);
  localparam int W = imusrf_pkg::CH_W;
  localparam int N = imusrf_pkg::CH_N;

  function automatic logic [15:0] sat16(input logic signed [35:0] v);
    if (v > 36'sh00007FFF) return 16'h7FFF;
    if (v < -36'sh00008000) return 16'h8000;
    return v[15:0];
  endfunction : sat16

  function automatic logic [6:0] seq_span(input logic [4:0] d);
    if (d > imusrf_pkg::SLOW_D_LIMIT) return 7'h01;
    return imusrf_pkg::SEQ_FULL >> d;
  endfunction : seq_span

  logic [15:0] spc_r;
  logic [15:0] frc_r;
  logic [2:0][15:0] bias_r;
  logic [2:0][15:0] gyro_r;
  logic [2:0][15:0] accel_r;
  logic [15:0] temp_r;
  logic [2:0][15:0] mag_r;
  logic [15:0] baro_r;
  logic new_data_r;
  logic [6:0] seq_r;
  logic [16:0] tick_cnt_r;
  logic ext_s1_r, ext_s2_r, ext_s3_r;
  logic tick_pend_r;
  imusrf_pkg::imusrf_state_t st_r;
  logic signed [W-1:0] smp_r [N];
  logic signed [W-1:0] avg1_r [N];
  logic signed [W-1:0] h1_r [N][128];
  logic signed [W-1:0] h2_r [N][128];
  logic signed [W+6:0] s1_r [N];
  logic signed [W+6:0] s2_r [N];
  logic signed [35:0] dacc_r [N];
  logic [6:0] wp_r;
  logic [7:0] fill_r;
  logic [16:0] dcnt_r;
  logic f_valid;
  imusrf_pkg::imusrf_chan_t f_data;

  // configuration decode
  wire clk_sel = spc_r[imusrf_pkg::SPC_CLK_BIT];
  wire [4:0] d_req = spc_r[imusrf_pkg::SPC_DEC_LSB +: 5];
  wire [4:0] d_eff = (d_req > imusrf_pkg::DEC_MAX) ? imusrf_pkg::DEC_MAX : d_req;
  wire [2:0] rng = frc_r[imusrf_pkg::FRC_RNG_LSB +: 3];
  wire [2:0] b_req = frc_r[imusrf_pkg::FRC_B_LSB +: 3];
  wire [2:0] b_min = (rng == imusrf_pkg::RNG_250) ? imusrf_pkg::MIN_B_250 :
                     (rng == imusrf_pkg::RNG_500) ? imusrf_pkg::MIN_B_500 : 3'h0;
  wire [2:0] b_eff = (b_req < b_min) ? b_min : b_req;
  wire [1:0] g_sh = (rng == imusrf_pkg::RNG_250) ? 2'h0 :
                    (rng == imusrf_pkg::RNG_500) ? 2'h1 : 2'h2;
  wire [7:0] n_taps = 8'h01 << b_eff;
  wire [6:0] old_idx = wp_r - n_taps[6:0];
  wire have_old = fill_r >= n_taps;
  wire [16:0] dec_last = 17'((18'h00001 << d_eff) - 18'h00001);
  wire dec_done = dcnt_r == dec_last;
  wire [6:0] span = seq_span(d_eff);

  // bus decode
  wire wr_spc = reg_req.wr && reg_req.addr == imusrf_pkg::OFF_SAMPLE_PERIOD;
  wire wr_frc = reg_req.wr && reg_req.addr == imusrf_pkg::OFF_FILTER_RANGE;
  wire restart = wr_spc || wr_frc;
  wire rd_slow = reg_req.rd && reg_req.addr >= imusrf_pkg::OFF_MAG0 &&
                 reg_req.addr <= imusrf_pkg::OFF_BARO && !reg_req.addr[0];
  wire [6:0] ridx = reg_req.addr - imusrf_pkg::OFF_GYRO0;

  // sample source selection
  wire int_tick = tick_cnt_r == 17'(TICK_CYCLES - 1);
  wire ext_tick = ext_s2_r && !ext_s3_r;
  wire sample_tick = clk_sel ? int_tick : ext_tick;
  wire pop = st_r == imusrf_pkg::ST_IDLE && (tick_pend_r || sample_tick) && f_valid;
  wire out_upd = st_r == imusrf_pkg::ST_STAGE2 && dec_done;
  wire slow_upd = out_upd && seq_r <= 7'h01;

  imusrf_fifo #(.W(W * N), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(raw_valid),
    .in_ready(raw_ready),
    .in_data(raw_data),
    .out_valid(f_valid),
    .out_ready(pop),
    .out_data(f_data)
  );

  // two averaging stages, decimation sum and final scaling
  logic signed [W+6:0] s1_nxt [N];
  logic signed [W+6:0] s2_nxt [N];
  logic signed [W-1:0] avg1 [N];
  logic signed [W-1:0] avg2 [N];
  logic signed [35:0] dacc_nxt [N];
  logic [15:0] res [N];
  always_comb begin
    for (int c = 0; c < N; c++) begin
      s1_nxt[c] = s1_r[c] + (W+7)'(smp_r[c]) - (have_old ? (W+7)'(h1_r[c][old_idx]) : '0);
      avg1[c] = W'(s1_nxt[c] >>> b_eff);
      s2_nxt[c] = s2_r[c] + (W+7)'(avg1_r[c]) - (have_old ? (W+7)'(h2_r[c][old_idx]) : '0);
      avg2[c] = W'(s2_nxt[c] >>> b_eff);
      dacc_nxt[c] = dacc_r[c] + 36'(avg2[c]);
      if (c < 3) begin
        res[c] = sat16(((dacc_nxt[c] >>> d_eff) >>> g_sh) +
                       (36'($signed(bias_r[c])) >>> g_sh));
      end else begin
        res[c] = sat16(dacc_nxt[c] >>> d_eff);
      end
    end
  end

  wire [15:0] rd_mux =
    (reg_req.addr == imusrf_pkg::OFF_SAMPLE_PERIOD) ? spc_r :
    (reg_req.addr == imusrf_pkg::OFF_FILTER_RANGE) ? frc_r :
    (reg_req.addr == imusrf_pkg::OFF_SLOW_SENSOR_SEQUENCE_COUNTER) ? {9'h000, seq_r} :
    (reg_req.addr == imusrf_pkg::OFF_DIAG) ? 16'(new_data_r) << imusrf_pkg::DIAG_NEW_BIT :
    (reg_req.addr == imusrf_pkg::OFF_GYRO_X_BIAS) ? bias_r[0] :
    (reg_req.addr == imusrf_pkg::OFF_GYRO_Y_BIAS) ? bias_r[1] :
    (reg_req.addr == imusrf_pkg::OFF_GYRO_Z_BIAS) ? bias_r[2] :
    (reg_req.addr == imusrf_pkg::OFF_TEMP) ? temp_r :
    (reg_req.addr == imusrf_pkg::OFF_BARO) ? baro_r :
    (ridx < 7'h06 && !ridx[0]) ? gyro_r[ridx[2:1]] :
    (ridx >= 7'h06 && ridx < 7'h0C && !ridx[0]) ? accel_r[2'(ridx[3:1] - 3'h3)] :
    (ridx >= 7'h0C && ridx < 7'h12 && !ridx[0]) ? mag_r[2'(ridx[3:1] - 3'h6)] : 16'h0000;

  // registers and bus
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      spc_r <= imusrf_pkg::SPC_RESET;
      frc_r <= imusrf_pkg::FRC_RESET;
      bias_r <= {3{imusrf_pkg::BIAS_RESET}};
      reg_rdata <= 16'h0000;
    end else begin
      if (wr_spc) spc_r <= reg_req.wdata & imusrf_pkg::SPC_MASK;
      if (wr_frc) frc_r <= reg_req.wdata & imusrf_pkg::FRC_MASK;
      if (reg_req.wr && reg_req.addr == imusrf_pkg::OFF_GYRO_X_BIAS) bias_r[0] <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == imusrf_pkg::OFF_GYRO_Y_BIAS) bias_r[1] <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == imusrf_pkg::OFF_GYRO_Z_BIAS) bias_r[2] <= reg_req.wdata;
      if (reg_req.rd) reg_rdata <= rd_mux;
    end
  end

  // sample clocks and aux line 4
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tick_cnt_r <= 17'h00000;
      {ext_s1_r, ext_s2_r, ext_s3_r} <= 3'h0;
      tick_pend_r <= 1'b0;
      aux4_oe <= 1'b0;
      aux4_out <= 1'b0;
    end else begin
      tick_cnt_r <= int_tick ? 17'h00000 : tick_cnt_r + 17'h00001;
      ext_s1_r <= aux4_in;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      // a tick spent by its own pop must not also stay pending
      tick_pend_r <= (sample_tick || tick_pend_r) && !pop;
      aux4_oe <= clk_sel && gpio4_dir;
      aux4_out <= clk_sel && gpio4_dir && gpio4_level;
    end
  end

  // processing sequence
  always_ff @(posedge ref_clk) begin
    if (!rst_n || restart) begin
      st_r <= imusrf_pkg::ST_IDLE;
      wp_r <= 7'h00;
      fill_r <= 8'h00;
      dcnt_r <= 17'h00000;
      for (int c = 0; c < N; c++) begin
        s1_r[c] <= '0;
        s2_r[c] <= '0;
        dacc_r[c] <= '0;
      end
    end else begin
      case (st_r)
        imusrf_pkg::ST_IDLE: begin
          if (pop) begin
            for (int c = 0; c < N; c++) smp_r[c] <= f_data[c];
            st_r <= imusrf_pkg::ST_STAGE1;
          end
        end
        imusrf_pkg::ST_STAGE1: begin
          for (int c = 0; c < N; c++) begin
            s1_r[c] <= s1_nxt[c];
            avg1_r[c] <= avg1[c];
            h1_r[c][wp_r] <= smp_r[c];
          end
          st_r <= imusrf_pkg::ST_STAGE2;
        end
        imusrf_pkg::ST_STAGE2: begin
          for (int c = 0; c < N; c++) begin
            s2_r[c] <= s2_nxt[c];
            h2_r[c][wp_r] <= avg1_r[c];
            dacc_r[c] <= dec_done ? '0 : dacc_nxt[c];
          end
          wp_r <= wp_r + 7'h01;
          if (fill_r != 8'h80) fill_r <= fill_r + 8'h01;
          dcnt_r <= dec_done ? 17'h00000 : dcnt_r + 17'h00001;
          st_r <= imusrf_pkg::ST_IDLE;
        end
        default: st_r <= imusrf_pkg::ST_IDLE;
      endcase
    end
  end

  // outputs, slow sensors, counter and new-data flag
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gyro_r <= '0;
      accel_r <= '0;
      temp_r <= 16'h0000;
      mag_r <= '0;
      baro_r <= 16'h0000;
      seq_r <= imusrf_pkg::SEQ_FULL;
      new_data_r <= 1'b0;
      sample_update <= 1'b0;
      slow_update <= 1'b0;
    end else begin
      sample_update <= out_upd && !restart;
      slow_update <= slow_upd && !restart;
      if (out_upd && !restart) begin
        for (int c = 0; c < 3; c++) begin
          gyro_r[c] <= res[c];
          accel_r[c] <= res[c + 3];
        end
        temp_r <= res[6];
        seq_r <= slow_upd ? span : seq_r - 7'h01;
      end
      if (slow_upd && !restart) begin
        mag_r <= mag_in;
        baro_r <= baro_in;
      end
      if (wr_spc) seq_r <= seq_span(reg_req.wdata[imusrf_pkg::SPC_DEC_LSB +: 5]);
      // set beats a read in the same cycle
      new_data_r <= (slow_upd && !restart) || (new_data_r && !rd_slow);
    end
  end

  property p_int_rate;
    @(posedge ref_clk) disable iff (!rst_n)
    clk_sel && int_tick |=> (tick_cnt_r == 17'h00000) ##1 (tick_cnt_r == 17'h00001);
  endproperty
  a_int_rate: assert property (p_int_rate) else $error("internal tick period wrong");
  property p_dec_interval;
    @(posedge ref_clk) disable iff (!rst_n)
    sample_update |-> $past(dcnt_r) == $past(dec_last);
  endproperty
  a_dec_interval: assert property (p_dec_interval) else $error("update off interval");
  property p_ext_src;
    @(posedge ref_clk) disable iff (!rst_n)
    !clk_sel && sample_tick |-> $past(aux4_in, 2) && !$past(aux4_in, 3);
  endproperty
  a_ext_src: assert property (p_ext_src) else $error("external tick without edge");
  property p_new_set;
    @(posedge ref_clk) disable iff (!rst_n)
    slow_upd && !restart |=> new_data_r && slow_update;
  endproperty
  a_new_set: assert property (p_new_set) else $error("new-data bit not set");
  property p_new_clr;
    @(posedge ref_clk) disable iff (!rst_n)
    rd_slow && !slow_upd |=> !new_data_r;
  endproperty
  a_new_clr: assert property (p_new_clr) else $error("new-data bit not cleared");
  property p_diag_keep;
    @(posedge ref_clk) disable iff (!rst_n)
    new_data_r && reg_req.rd && reg_req.addr == imusrf_pkg::OFF_DIAG |=> new_data_r;
  endproperty
  a_diag_keep: assert property (p_diag_keep) else $error("diag read cleared bit");
  property p_seq_full;
    @(posedge ref_clk) disable iff (!rst_n)
    slow_update && d_eff == 5'h00 |-> seq_r == imusrf_pkg::SEQ_FULL;
  endproperty
  a_seq_full: assert property (p_seq_full) else $error("counter not 16 on fresh data");
  property p_min_taps;
    @(posedge ref_clk) disable iff (!rst_n)
    rng == imusrf_pkg::RNG_250 |-> n_taps >= 8'h10;
  endproperty
  a_min_taps: assert property (p_min_taps) else $error("taps below range minimum");
  property p_aux4_input;
    @(posedge ref_clk) disable iff (!rst_n)
    !clk_sel ##1 !clk_sel |-> !aux4_oe;
  endproperty
  a_aux4_input: assert property (p_aux4_input) else $error("aux line 4 driven");
  c_slow: cover property (@(posedge ref_clk) disable iff (!rst_n) slow_update);
  c_decim: cover property (@(posedge ref_clk) disable iff (!rst_n) sample_update && d_eff != 5'h00);
  c_ext: cover property (@(posedge ref_clk) disable iff (!rst_n) !clk_sel && pop);
  c_clear: cover property (@(posedge ref_clk) disable iff (!rst_n) new_data_r && rd_slow);
endmodule : imusrf_filter

// ==== dv/imusrf_host_model.sv ====
`timescale 1ns/1ps
module imusrf_host_model (
  // clock
  input wire logic ref_clk,
  // register port of the device
  output imusrf_pkg::imusrf_reg_req_t reg_req,
  input wire logic [15:0] reg_rdata
);
  initial reg_req = '0;
  // whole-word strobe for one cycle; released address and data are inverted
  // range and filter size travel in one word, so range never lags the size
  task automatic access(input logic w, input logic [6:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    @(negedge ref_clk);
    reg_req = {w, ~w, a, d};
    @(posedge ref_clk);
    @(negedge ref_clk);
    q = reg_rdata;
    reg_req = {2'b00, ~a, ~d};
  endtask : access
endmodule : imusrf_host_model

// ==== dv/imusrf_filter_tb.sv ====
`timescale 1ns/1ps
module imusrf_filter_tb;
  localparam int TK = 40;
  localparam logic [15:0] FT [4] = '{16'hFC02, 16'h0100, 16'h0201, 16'h0407};
  localparam logic [15:0] ST [4] = '{16'hE0FF, 16'h0201, 16'h0501, 16'h0301};
  localparam int NT [4] = '{20, 3, 2, 3};
  localparam logic [6:0] RA [9] = '{7'h1A, 7'h1C, 7'h1E, 7'h36, 7'h38, 7'h3A, 7'h3C, 7'h3E,
                                    7'h37};
  localparam logic [15:0] RV [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0402,
                                     16'h0010, 16'h0000, 16'h0000, 16'h0000};
  logic ref_clk, rst_n, raw_valid, raw_ready, aux4_in, aux4_out, aux4_oe;
  logic gpio4_dir, gpio4_level, sample_update, slow_update, slow_seen;
  imusrf_pkg::imusrf_reg_req_t reg_req;
  logic [15:0] reg_rdata, baro_in;
  imusrf_pkg::imusrf_chan_t raw_data;
  logic [2:0][15:0] mag_in;
  int bad_count, n_checks, cyc, last_cyc, gap, upd_n, seen_n, bb, dd, sh, cnt, ext;
  logic [31:0] seed;
  longint bias [3];
  longint h1 [7][$];
  longint h2 [7][$];
  logic [15:0] exp_o [7];
  imusrf_pkg::imusrf_chan_t smp_q [$];

  imusrf_filter #(.TICK_CYCLES(TK), .FIFO_DEPTH(16)) imusrf_filter_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .raw_valid(raw_valid), .raw_ready(raw_ready), .raw_data(raw_data), .mag_in(mag_in),
    .baro_in(baro_in), .aux4_in(aux4_in), .aux4_out(aux4_out), .aux4_oe(aux4_oe),
    .gpio4_dir(gpio4_dir), .gpio4_level(gpio4_level), .sample_update(sample_update),
    .slow_update(slow_update));
  imusrf_host_model imusrf_host_model_inst (
    .ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

  always #5 ref_clk = ~ref_clk;

  // update monitor: spacing and slow flag of every output update
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (sample_update === 1'b1) begin
      gap <= cyc - last_cyc;
      last_cyc <= cyc;
      slow_seen <= slow_update;
      upd_n <= upd_n + 1;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic int span(int d);
    return d <= 4 ? 16 >> d : 1;
  endfunction : span

  function automatic logic [15:0] sat16(longint v);
    return v > 32767 ? 16'h7FFF : (v < -32768 ? 16'h8000 : 16'(v));
  endfunction : sat16

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] q;
    imusrf_host_model_inst.access(1'b0, a, 16'h0000, q);
    chk(q, e);
  endtask : rdchk

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] q;
    imusrf_host_model_inst.access(1'b1, a, d, q);
  endtask : wr

  // configure both controls and restart the model's averaging history
  task automatic cfg(input logic [15:0] frc, input logic [15:0] spc);
    int mn;
    wr(7'h38, frc);
    wr(7'h36, spc);
    rdchk(7'h38, frc & 16'h0707);
    rdchk(7'h36, spc & 16'h1F01);
    mn = frc[10:8] == 3'h1 ? 4 : (frc[10:8] == 3'h2 ? 2 : 0);
    bb = frc[2:0] < mn ? mn : frc[2:0];
    sh = frc[10:8] == 3'h1 ? 0 : (frc[10:8] == 3'h2 ? 1 : 2);
    dd = spc[12:8];
    ext = !spc[0];
    cnt = span(dd);
    for (int c = 0; c < 7; c++) begin
      h1[c] = {};
      h2[c] = {};
      repeat (1 << bb) begin
        h1[c].push_back(0);
        h2[c].push_back(0);
      end
    end
  endtask : cfg

  // two cascaded moving averages, then decimation average and bias
  task automatic model_update();
    longint a [7];
    longint v;
    imusrf_pkg::imusrf_chan_t x;
    a = '{default: 0};
    repeat (1 << dd) begin
      x = smp_q.pop_front();
      for (int c = 0; c < 7; c++) begin
        h1[c].push_back(longint'($signed(x[c])));
        void'(h1[c].pop_front());
        h2[c].push_back(h1[c].sum() >>> bb);
        void'(h2[c].pop_front());
        a[c] += h2[c].sum() >>> bb;
      end
    end
    for (int c = 0; c < 7; c++) begin
      v = a[c] >>> dd;
      if (c < 3)
        v = (v >>> sh) + (bias[c] >>> sh);
      exp_o[c] = sat16(v);
    end
  endtask : model_update

  task automatic push(int n);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      raw_valid = 1'b1;
      for (int c = 0; c < 7; c++) begin
        r = rnd();
        raw_data[c] = 20'($signed(r[17:0]));
      end
      do @(posedge ref_clk); while (raw_ready !== 1'b1);
      smp_q.push_back(raw_data);
    end
    @(negedge ref_clk);
    raw_valid = 1'b0;
    raw_data = ~raw_data;
  endtask : push

  task automatic tog(int n);
    repeat (n) begin
      repeat (20) @(negedge ref_clk);
      aux4_in = 1'b1;
      repeat (20) @(negedge ref_clk);
      aux4_in = 1'b0;
    end
  endtask : tog

  task automatic run_updates(int k);
    int w;
    for (int i = 0; i < k; i++) begin
      w = 0;
      while (upd_n == seen_n && w < 5000) begin
        @(negedge ref_clk);
        w++;
      end
      chk(16'(upd_n - seen_n), 16'h0001);
      seen_n++;
      chk(slow_seen, cnt <= 1);
      if (i > 0 && !ext)
        chk(16'(gap), 16'(TK << dd));
      cnt = cnt <= 1 ? span(dd) : cnt - 1;
      model_update();
      for (int c = 0; c < 7; c++)
        rdchk(c < 6 ? 7'h04 + 7'(2 * c) : 7'h18, exp_o[c]);
      rdchk(7'h3A, 16'(cnt));
      if (slow_seen) begin
        rdchk(7'h3C, 16'h0080);
        rdchk(7'h3C, 16'h0080);
        rdchk(7'h10, mag_in[0]);
        rdchk(7'h12, mag_in[1]);
        rdchk(7'h14, mag_in[2]);
        rdchk(7'h16, baro_in);
        rdchk(7'h3C, 16'h0000);
      end
      mag_in = 48'({rnd(), rnd()});
      baro_in = 16'(rnd());
    end
  endtask : run_updates

  initial begin
    logic [31:0] r;
    ref_clk = 1'b0;
    rst_n = 1'b0;
    raw_valid = 1'b0;
    raw_data = '0;
    mag_in = '0;
    baro_in = 16'h0000;
    aux4_in = 1'b0;
    gpio4_dir = 1'b1;
    gpio4_level = 1'b1;
    seed = 32'hD025;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(aux4_oe, 1'b1);
    chk(aux4_out, gpio4_level);
    for (int i = 0; i < 9; i++)
      rdchk(RA[i], RV[i]);
    wr(7'h3A, 16'hFFFF);
    rdchk(7'h3A, 16'h0010);
    for (int p = 0; p < 4; p++) begin
      if (p == 1) begin
        r = rnd();
        bias = '{-10, 100, longint'($signed(r[15:0]))};
        for (int c = 0; c < 3; c++) begin
          wr(7'h1A + 7'(2 * c), 16'(bias[c]));
          rdchk(7'h1A + 7'(2 * c), 16'(bias[c]));
        end
      end
      cfg(FT[p], ST[p]);
      fork
        push(NT[p] << dd);
        run_updates(NT[p]);
      join
    end
    cfg(16'h0402, 16'h0000);
    repeat (3) @(negedge ref_clk);
    chk(aux4_oe, 1'b0);
    gpio4_dir = 1'b0;
    // a tick left pending from the internal clock may take this sample
    push(1);
    repeat (100) @(negedge ref_clk);
    if (upd_n == seen_n)
      tog(1);
    run_updates(1);
    push(16);
    chk(raw_ready, 1'b0);
    repeat (100) @(negedge ref_clk);
    chk(16'(upd_n - seen_n), 16'h0000);
    fork
      tog(16);
      run_updates(16);
    join
    test_done();
  end

  initial begin
    #200000;
    bad_count++;
    test_done();
  end
endmodule : imusrf_filter_tb
